// ### sim/local_bus_sideband_checker.sv
// Concurrent property checker for the local bus sideband controller
`timescale 1ns/100ps
`default_nettype none
module local_bus_sideband_checker
   import sideband_pkg::*;
(
   // Clock, reset and watched ports
   input wire logic clock, rst_n, req_taken, addr_strobe_n, rsp_valid,
   input wire logic rsp_fill, ready_n, bus_mio, bus_dc, bus_wr, bus_lock_n,
   input wire logic lookup_a20_mask, int_take, cop_exception, cop_go,
   input wire logic replacement_way_oe, replacement_way_valid_oe,
   input wire logic cop_op_valid, cop_engaged_n,
   input wire logic [1:0] rsp_be_n,
   input wire logic [7:0] int_vector,
   input wire logic [15:0] rsp_data, data_in,
   input wire logic [23:1] bus_addr,
   input wire sideband_pkg::cop_kind_t cop_op_kind
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence inta_start;
      !addr_strobe_n && !bus_mio && !bus_dc && !bus_wr;
   endsequence
   a_taken_strobe: assert property (req_taken |-> !addr_strobe_n)
      else $error("request taken without address strobe");
   a_read_capture: assert property (
      rsp_valid |-> !$past(ready_n) && rsp_data == $past(data_in))
      else $error("read data not captured at termination");
   a_inta_locked: assert property (inta_start |-> !bus_lock_n)
      else $error("acknowledge cycle not locked");
   a_fill_bytes: assert property (
      rsp_valid && rsp_fill |-> rsp_be_n == 2'b00)
      else $error("fill did not store both bytes");
   a_rpl_oe_pair: assert property (
      replacement_way_valid_oe == replacement_way_oe)
      else $error("replacement outputs enabled apart");
   a_a20_forced: assert property (
      !addr_strobe_n && lookup_a20_mask |-> !bus_addr[20])
      else $error("address bit 20 not masked");
   a_cop_exc_vec: assert property (
      cop_exception |-> int_take && int_vector == COP_EXC_VECTOR)
      else $error("coprocessor exception with wrong vector");
   a_cop_wait_busy: assert property (
      cop_op_valid && cop_op_kind == COP_WAITING && !cop_engaged_n |=> !cop_go)
      else $error("waiting op issued while coprocessor engaged");
endmodule  // local_bus_sideband_checker
bind local_bus_sideband local_bus_sideband_checker
   local_bus_sideband_checker_i (.*);
`default_nettype wire

// ### sim/local_bus_sideband_tb.sv
// Directed testbench for the local bus sideband controller
`timescale 1ns/100ps
`default_nettype none
module local_bus_sideband_tb;
   import sideband_pkg::*;
   logic clock = 1'b0;
   logic rst_n, reg_write, reg_read, req_valid, req_mio, req_dc, req_wr;
   logic req_lock, req_code, req_noncache, maskable_irq, nonmaskable_irq;
   logic iret_done, halt_enter, cop_op_valid, cop_transfer_request;
   logic cop_engaged_n, cop_fault_n, ready_n, next_address_req_n, hold_ack;
   logic cacheability_n, cache_invalidate_n, addr_bit20_mask_n, req_taken;
   logic rsp_valid, rsp_fill, cache_flush, lookup_a20_mask, resume, cop_go;
   logic cop_exception, upper_byte_en_n, lower_byte_en_n, bus_mio, bus_dc;
   logic bus_wr, bus_lock_n, addr_strobe_n, data_oe, replacement_way, int_take;
   logic replacement_way_oe, replacement_way_valid_n, replacement_way_valid_oe;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, int_vector;
   logic [23:1] req_addr, bus_addr;
   logic [1:0] req_be_n, rsp_be_n, wait_cyc;
   logic [15:0] req_wdata, rsp_data, data_in, data_out;
   cop_kind_t cop_op_kind;
   int error_cnt = 0, checked = 0, cyc = 0;
   local_bus_sideband local_bus_sideband_i (.*);
   sys_bus_model sys_bus_model_i (.*);
   initial forever #10 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge clock);
      {reg_addr, reg_wdata, reg_write, reg_read} <= {a, d, w, !w};
      @(posedge clock);
      {reg_write, reg_read} <= 2'b00;
      @(negedge clock);
      if (!w)
         chk("reg_rdata", {8'h00, d}, {8'h00, reg_rdata});
   endtask
   task automatic req(input logic [23:1] a, input logic code, input int n);
      @(posedge clock);
      {req_addr, req_code, req_dc, req_valid} <= {a, code, !code, 1'b1};
      do @(negedge clock); while (req_taken !== 1'b1);
      @(posedge clock);
      req_valid <= 1'b0;
      repeat (n) begin
         do @(negedge clock); while (rsp_valid !== 1'b1);
         chk("rsp_data", a[16:1], rsp_data);
         chk("rsp_fill", 16'(n - 1), {15'h0000, rsp_fill});
         a = a ^ 23'h000001;
      end
   endtask
   task automatic tk(input logic [7:0] v);
      do @(negedge clock); while (int_take !== 1'b1);
      chk("int_vector", {8'h00, v}, {8'h00, int_vector});
      @(posedge clock);
   endtask
   initial begin
      {rst_n, reg_write, reg_read, req_valid, req_wr, req_lock, req_code,
       req_noncache, maskable_irq, nonmaskable_irq, iret_done, halt_enter,
       cop_op_valid, cop_transfer_request, hold_ack, cacheability_n} = '0;
      {req_mio, req_dc, cop_engaged_n, cop_fault_n, cache_invalidate_n,
       addr_bit20_mask_n} = '1;
      {reg_addr, reg_wdata, req_addr, req_be_n, req_wdata} = '0;
      wait_cyc = 2'd2;
      cop_op_kind = COP_PLAIN;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      acc(1'b0, CFG0_OFS, CFG0_RST);
      acc(1'b0, 4'hf, 8'h00);
      chk("way_oe", 16'h0000, {15'h0000, replacement_way_oe});
      req(23'h012345, 1'b0, 1);
      req(23'h000404, 1'b1, 1);
      acc(1'b1, CFG0_OFS, 8'h0b);
      acc(1'b1, CFG1_OFS, 8'h01);
      acc(1'b0, CFG0_OFS, 8'h0b);
      {wait_cyc, addr_bit20_mask_n, cache_invalidate_n} <= 4'b0000;
      repeat (3) @(negedge clock);
      chk("cache_flush", 16'h0001, {15'h0000, cache_flush});
      req(23'h080010, 1'b1, 2);
      chk("way_oe", 16'h0001, {15'h0000, replacement_way_oe});
      @(posedge clock);
      nonmaskable_irq <= 1'b1;
      tk(NMI_VECTOR);
      iret_done <= 1'b1;
      @(posedge clock);
      {iret_done, maskable_irq} <= 2'b01;
      acc(1'b1, CTRL_OFS, 8'h01);
      tk(8'h5a);
      maskable_irq <= 1'b0;
      {cop_op_valid, cop_engaged_n} <= 2'b10;
      cop_op_kind <= COP_WAITING;
      repeat (3) @(negedge clock);
      chk("cop_go", 16'h0000, {15'h0000, cop_go});
      @(posedge clock);
      cop_engaged_n <= 1'b1;
      repeat (3) @(negedge clock);
      chk("cop_go", 16'h0001, {15'h0000, cop_go});
      @(posedge clock);
      cop_op_kind <= COP_PLAIN;
      cop_fault_n <= 1'b0;
      tk(COP_EXC_VECTOR);
      results();
   end
endmodule  // local_bus_sideband_tb
`default_nettype wire

// ### sim/sys_bus_model.sv
// Behavioural system slave: cycle termination, read data, vector
`timescale 1ns/100ps
`default_nettype none
module sys_bus_model #(
   parameter logic [7:0] VEC = 8'h5a
) (
   // Clock, reset, bus pins and bench knob
   input wire logic clock, rst_n, addr_strobe_n, bus_mio,
   input wire logic [23:1] bus_addr,
   input wire logic [1:0] wait_cyc,
   // Answers
   output logic ready_n, next_address_req_n,
   output logic [15:0] data_in
);
   // ----------------------------------------------------------------
   // One cycle served at a time, oldest first
   // ----------------------------------------------------------------
   logic [15:0] q[$];
   logic strobe_q;
   int cnt;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q.delete();
         cnt = 0;
         {strobe_q, ready_n, next_address_req_n} <= 3'b111;
         data_in <= 16'h0000;
      end else begin
         strobe_q <= addr_strobe_n;
         if (!addr_strobe_n && strobe_q)
            q.push_back(bus_mio ? bus_addr[16:1] : {8'h00, VEC});
         if (!ready_n) begin
            void'(q.pop_front());
            cnt = 0;
            ready_n <= 1'b1;
            // Released bus must not look like held data
            data_in <= ~data_in;
         end else if (q.size() != 0 && cnt >= wait_cyc) begin
            ready_n <= 1'b0;
            data_in <= q[0];
         end else if (q.size() != 0) begin
            cnt++;
         end
      end
   end
endmodule  // sys_bus_model
`default_nettype wire

// ### verilog/local_bus_sideband.sv
// Bus cycle, interrupt, cache sideband and coprocessor handshake logic
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Non-pipelined strobe low only first clock
// - Pipelined strobe held until prior cycle ends
// - Ready on read captures data, ends cycle
// - Next-address request drives next cycle early
// - Maskable request level, gated by flag bit
// - Two locked acknowledges, second reads vector
// - Nonmaskable edge uses vector 2, no acknowledge
// - One nonmaskable edge stored until return
// - Halt in nonmaskable handler ignores nonmaskable
// - Nonmaskable needs eight double-rate periods low
// - Cacheable reads become fills, exceptions excluded
// - Code fill two cycles, data fill operand
// - Fill ignores byte enables, stores both bytes
// - Cacheability ignored until enable bit set
// - Invalidate input and hold invalidation gated
// - Replacement way shown, qualified during fills
// - Replacement outputs floated until enabled
// - Address bit 20 masked when enabled, unpaged
// - Coprocessor ports, operands paced by request
// - Waiting coprocessor ops stall while engaged
// - Coprocessor fault raises exception 16
module local_bus_sideband
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Core bus requests
   input wire logic req_valid,
   input wire logic [23:1] req_addr,
   input wire logic [1:0] req_be_n,
   input wire logic req_mio,
   input wire logic req_dc,
   input wire logic req_wr,
   input wire logic req_lock,
   input wire logic req_code,
   input wire logic req_noncache,
   input wire logic [15:0] req_wdata,
   output logic req_taken,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic [1:0] rsp_be_n,
   output logic rsp_fill,
   // Cache control towards the core
   output logic cache_flush,
   output logic lookup_a20_mask,
   // Interrupt and execution control
   input wire logic maskable_irq,
   input wire logic nonmaskable_irq,
   input wire logic iret_done,
   input wire logic halt_enter,
   output logic int_take,
   output logic [7:0] int_vector,
   output logic resume,
   // Coprocessor
   input wire logic cop_op_valid,
   input wire sideband_pkg::cop_kind_t cop_op_kind,
   input wire logic cop_transfer_request,
   input wire logic cop_engaged_n,
   input wire logic cop_fault_n,
   output logic cop_go,
   output logic cop_exception,
   // Local bus pins
   output logic [23:1] bus_addr,
   output logic upper_byte_en_n,
   output logic lower_byte_en_n,
   output logic bus_mio,
   output logic bus_dc,
   output logic bus_wr,
   output logic bus_lock_n,
   output logic addr_strobe_n,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   input wire logic ready_n,
   input wire logic next_address_req_n,
   // Cache sideband pins
   input wire logic cacheability_n,
   input wire logic cache_invalidate_n,
   input wire logic hold_ack,
   output logic replacement_way,
   output logic replacement_way_oe,
   output logic replacement_way_valid_n,
   output logic replacement_way_valid_oe,
   input wire logic addr_bit20_mask_n
);
   import sideband_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] cfg0_r, cfg1_r, ctrl_r;
   logic cyc_r, t2_r, pipe_r;
   src_t cur_src_r, nxt_src_r, sel_src;
   logic cur_wr_r, nxt_wr_r, cur_cand_r, nxt_cand_r;
   logic cur_code_r, nxt_code_r;
   logic [23:1] cur_addr_r, nxt_addr_r, sel_addr;
   logic [15:0] cur_wdata_r, nxt_wdata_r;
   logic [1:0] sel_be_n;
   logic sel_valid, sel_mio, sel_dc, sel_wr, sel_lock, sel_code, sel_cand;
   logic core_ok, start_t1, start_pipe, term, fill_now, a20_on;
   logic inta_busy_r, inta_req_r, fill2_req_r;
   logic [23:1] fill2_addr_r;
   logic nmi_prev_r, nmi_busy_r, nmi_pend_r, nmi_edge, irq_go;
   logic [3:0] nmi_low_r;
   logic halted_r, halt_in_nmi_r, hold_prev_r;

   // Cacheable candidate: memory read, unlocked, not acknowledge
   function automatic logic fill_cand(input logic mio, input logic wr,
                                      input logic lock, input logic nc);
      fill_cand = mio && !wr && !lock && !nc;
   endfunction

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_r <= CFG0_RST;
         cfg1_r <= CFG1_RST;
      end else if (reg_write) begin
         if (reg_addr == CFG0_OFS) cfg0_r <= reg_wdata;
         if (reg_addr == CFG1_OFS) cfg1_r <= reg_wdata;
      end
   end

   // Flag bit also cleared by hardware on maskable entry
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (irq_go) begin
         ctrl_r[CTRL_IF_BIT] <= 1'b0;
      end else if (reg_write && reg_addr == CTRL_OFS) begin
         ctrl_r <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            CFG0_OFS: reg_rdata <= cfg0_r;
            CFG1_OFS: reg_rdata <= cfg1_r;
            CTRL_OFS: reg_rdata <= ctrl_r;
            STAT_OFS: reg_rdata <= {1'b0, !cop_engaged_n, halted_r,
                                    inta_busy_r, nmi_pend_r, nmi_busy_r,
                                    pipe_r, cyc_r};
            VECT_OFS: reg_rdata <= int_vector;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Next request selection
   // ----------------------------------------------------------------
   assign a20_on = cfg0_r[CFG0_A20_BIT] && !ctrl_r[CTRL_PG_BIT]
                   && !addr_bit20_mask_n;
   // Operand ports wait for the coprocessor; stale request guard
   assign core_ok = req_valid && !req_taken && !halted_r
      && !(!req_mio && (req_addr == COP_OPA_PORT
           || req_addr == COP_OPB_PORT) && !cop_transfer_request);

   always_comb begin
      sel_valid = 1'b1;
      sel_src = SRC_CORE;
      sel_addr = req_addr;
      sel_be_n = req_be_n;
      sel_mio = req_mio;
      sel_dc = req_dc;
      sel_wr = req_wr;
      sel_lock = req_lock;
      sel_code = req_code;
      sel_cand = fill_cand(req_mio, req_wr, req_lock, req_noncache);
      if (inta_req_r) begin
         sel_src = inta_busy_r && cur_src_r == SRC_INTA1 && !cyc_r
                   ? SRC_INTA2 : SRC_INTA1;
         sel_addr = '0;
         sel_be_n = 2'b10;
         sel_mio = 1'b0;
         sel_dc = 1'b0;
         sel_wr = 1'b0;
         sel_lock = 1'b1;
         sel_code = 1'b0;
         sel_cand = 1'b0;
      end else if (fill2_req_r) begin
         sel_src = SRC_FILL2;
         sel_addr = fill2_addr_r;
         sel_be_n = 2'b00;
         sel_mio = 1'b1;
         sel_dc = 1'b0;
         sel_wr = 1'b0;
         sel_lock = 1'b0;
         sel_code = 1'b1;
         sel_cand = 1'b1;
      end else begin
         sel_valid = core_ok;
      end
      if (a20_on) sel_addr[20] = 1'b0;
   end

   // ----------------------------------------------------------------
   // Bus cycle sequencing
   // ----------------------------------------------------------------
   assign term = cyc_r && t2_r && !ready_n;
   assign start_t1 = sel_valid && (!cyc_r || (term && !pipe_r));
   assign start_pipe = sel_valid && cyc_r && t2_r && !pipe_r && ready_n
                       && !next_address_req_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cyc_r <= 1'b0;
         t2_r <= 1'b0;
         pipe_r <= 1'b0;
         addr_strobe_n <= 1'b1;
      end else if (start_t1) begin
         cyc_r <= 1'b1;
         t2_r <= 1'b0;
         addr_strobe_n <= 1'b0;
      end else if (start_pipe) begin
         pipe_r <= 1'b1;
         addr_strobe_n <= 1'b0;
      end else if (term) begin
         cyc_r <= pipe_r;
         pipe_r <= 1'b0;
         addr_strobe_n <= 1'b1;
      end else begin
         t2_r <= cyc_r;
         if (!pipe_r) addr_strobe_n <= 1'b1;
      end
   end

   // Pins show the newest issued cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_addr <= ADDR_RST;
         upper_byte_en_n <= 1'b0;
         lower_byte_en_n <= 1'b0;
         bus_mio <= 1'b0;
         bus_dc <= 1'b1;
         bus_wr <= 1'b0;
         bus_lock_n <= 1'b1;
      end else if (start_t1 || start_pipe) begin
         bus_addr <= sel_addr;
         upper_byte_en_n <= sel_be_n[1];
         lower_byte_en_n <= sel_be_n[0];
         bus_mio <= sel_mio;
         bus_dc <= sel_dc;
         bus_wr <= sel_wr;
         bus_lock_n <= !sel_lock;
      end
   end

   // Attributes of the cycle in progress and of the pipelined one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur_src_r <= SRC_CORE;
         cur_wr_r <= 1'b0;
         cur_cand_r <= 1'b0;
         cur_code_r <= 1'b0;
         cur_addr_r <= '0;
         cur_wdata_r <= '0;
         nxt_src_r <= SRC_CORE;
         nxt_wr_r <= 1'b0;
         nxt_cand_r <= 1'b0;
         nxt_code_r <= 1'b0;
         nxt_addr_r <= '0;
         nxt_wdata_r <= '0;
      end else if (start_t1) begin
         cur_src_r <= sel_src;
         cur_wr_r <= sel_wr;
         cur_cand_r <= sel_cand;
         cur_code_r <= sel_code;
         cur_addr_r <= sel_addr;
         cur_wdata_r <= req_wdata;
      end else if (start_pipe) begin
         nxt_src_r <= sel_src;
         nxt_wr_r <= sel_wr;
         nxt_cand_r <= sel_cand;
         nxt_code_r <= sel_code;
         nxt_addr_r <= sel_addr;
         nxt_wdata_r <= req_wdata;
      end else if (term && pipe_r) begin
         cur_src_r <= nxt_src_r;
         cur_wr_r <= nxt_wr_r;
         cur_cand_r <= nxt_cand_r;
         cur_code_r <= nxt_code_r;
         cur_addr_r <= nxt_addr_r;
         cur_wdata_r <= nxt_wdata_r;
      end
   end

   // Write data follows the cycle in progress, not the pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= '0;
         data_oe <= 1'b0;
         req_taken <= 1'b0;
      end else begin
         data_out <= start_t1 ? req_wdata
                   : (term && pipe_r) ? nxt_wdata_r : cur_wdata_r;
         data_oe <= start_t1 ? sel_wr
                  : term ? (pipe_r && nxt_wr_r) : (cyc_r && cur_wr_r);
         req_taken <= (start_t1 || start_pipe) && sel_src == SRC_CORE;
      end
   end

   // ----------------------------------------------------------------
   // Termination: read capture and cache fills
   // ----------------------------------------------------------------
   assign fill_now = term && cur_cand_r && !cur_wr_r
                     && cfg0_r[CFG0_KEN_BIT] && !cacheability_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_be_n <= 2'b11;
         rsp_fill <= 1'b0;
      end else begin
         rsp_valid <= term && !cur_wr_r
                      && (cur_src_r == SRC_CORE || cur_src_r == SRC_FILL2);
         if (term && !cur_wr_r) begin
            rsp_data <= data_in;
            rsp_fill <= fill_now;
            rsp_be_n <= fill_now ? 2'b00
                      : {upper_byte_en_n, lower_byte_en_n};
         end
      end
   end

   // Code fills fetch the other word of the 4-byte line
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fill2_req_r <= 1'b0;
         fill2_addr_r <= '0;
      end else if (fill_now && cur_code_r && cur_src_r == SRC_CORE) begin
         fill2_req_r <= 1'b1;
         fill2_addr_r <= cur_addr_r ^ 23'h000001;
      end else if (sel_src == SRC_FILL2 && (start_t1 || start_pipe)) begin
         fill2_req_r <= 1'b0;
      end
   end

   // Way toggles per fill when two-way, stays 0 direct-mapped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         replacement_way <= 1'b0;
         replacement_way_valid_n <= 1'b1;
         replacement_way_oe <= 1'b0;
         replacement_way_valid_oe <= 1'b0;
      end else begin
         replacement_way_oe <= cfg1_r[CFG1_RPL_BIT];
         replacement_way_valid_oe <= cfg1_r[CFG1_RPL_BIT];
         replacement_way_valid_n <= !(cyc_r && !term && cur_cand_r
            && cfg0_r[CFG0_KEN_BIT] && !cacheability_n);
         if (!cfg1_r[CFG1_WAY_BIT]) replacement_way <= 1'b0;
         else if (fill_now) replacement_way <= !replacement_way;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cache_flush <= 1'b0;
         hold_prev_r <= 1'b0;
         lookup_a20_mask <= 1'b0;
      end else begin
         hold_prev_r <= hold_ack;
         cache_flush <= (cfg0_r[CFG0_INV_BIT] && !cache_invalidate_n)
            || (cfg0_r[CFG0_HLD_BIT] && hold_ack && !hold_prev_r);
         lookup_a20_mask <= a20_on;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_go = maskable_irq && ctrl_r[CTRL_IF_BIT] && !inta_busy_r
                   && !nmi_edge;
   // Edge counts only after the input stayed low long enough
   assign nmi_edge = nonmaskable_irq && !nmi_prev_r
                     && nmi_low_r >= 4'(NMI_LOW_CYC);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nmi_prev_r <= 1'b0;
         nmi_low_r <= 4'h0;
      end else begin
         nmi_prev_r <= nonmaskable_irq;
         if (nonmaskable_irq) nmi_low_r <= 4'h0;
         else if (nmi_low_r < 4'(NMI_LOW_CYC)) nmi_low_r <= nmi_low_r + 4'h1;
      end
   end

   // Two locked acknowledge cycles, vector taken from the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         inta_busy_r <= 1'b0;
         inta_req_r <= 1'b0;
      end else if (irq_go) begin
         inta_busy_r <= 1'b1;
         inta_req_r <= 1'b1;
      end else if (inta_req_r && (start_t1 || start_pipe)) begin
         inta_req_r <= 1'b0;
      end else if (term && cur_src_r == SRC_INTA1) begin
         inta_req_r <= 1'b1;
      end else if (term && cur_src_r == SRC_INTA2) begin
         inta_busy_r <= 1'b0;
      end
   end

   // The return that consumes a pending edge wins over setting a new one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nmi_busy_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end else if (nmi_edge && !nmi_busy_r && !halt_in_nmi_r) begin
         nmi_busy_r <= 1'b1;
      end else if (iret_done && nmi_busy_r) begin
         nmi_busy_r <= nmi_pend_r || nmi_edge;
         nmi_pend_r <= 1'b0;
      end else if (nmi_edge) begin
         nmi_pend_r <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int_take <= 1'b0;
         int_vector <= 8'h00;
         cop_exception <= 1'b0;
      end else begin
         int_take <= 1'b0;
         cop_exception <= 1'b0;
         if (term && cur_src_r == SRC_INTA2) begin
            int_take <= 1'b1;
            int_vector <= data_in[7:0];
         end else if ((nmi_edge && !nmi_busy_r && !halt_in_nmi_r)
                      || (iret_done && nmi_busy_r
                          && (nmi_pend_r || nmi_edge))) begin
            int_take <= 1'b1;
            int_vector <= NMI_VECTOR;
         end else if (cop_op_valid && !cop_fault_n
                      && cop_op_kind != COP_INIT_CLEAR
                      && cop_op_kind != COP_NOWAIT_STORE
                      && !(cop_op_kind == COP_WAITING
                           && !cop_engaged_n)) begin
            cop_exception <= 1'b1;
            int_take <= 1'b1;
            int_vector <= COP_EXC_VECTOR;
         end
      end
   end

   // Halt leaves on an unmasked request; nonmaskable only outside
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         halted_r <= 1'b0;
         halt_in_nmi_r <= 1'b0;
         resume <= 1'b0;
      end else if (halt_enter && !halted_r) begin
         halted_r <= 1'b1;
         halt_in_nmi_r <= nmi_busy_r;
         resume <= 1'b0;
      end else if (halted_r && (irq_go
                   || (nmi_edge && !halt_in_nmi_r))) begin
         halted_r <= 1'b0;
         halt_in_nmi_r <= 1'b0;
         resume <= 1'b1;
      end else begin
         resume <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Coprocessor issue
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cop_go <= 1'b0;
      end else begin
         cop_go <= cop_op_valid && !(cop_op_kind == COP_WAITING
                   && !cop_engaged_n) && (cop_fault_n
                   || cop_op_kind == COP_INIT_CLEAR
                   || cop_op_kind == COP_NOWAIT_STORE);
      end
   end

endmodule // local_bus_sideband

`default_nettype wire

// ### verilog/sideband_pkg.sv
// Shared constants and types for the local bus sideband controller
package sideband_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] CFG0_OFS = 4'h0;
   localparam logic [3:0] CFG1_OFS = 4'h1;
   localparam logic [3:0] CTRL_OFS = 4'h2;
   localparam logic [3:0] STAT_OFS = 4'h3;
   localparam logic [3:0] VECT_OFS = 4'h4;

   // config_reg_0 fields
   localparam int CFG0_KEN_BIT = 0;  // cacheability_input_enable
   localparam int CFG0_INV_BIT = 1;  // invalidate_input_enable
   localparam int CFG0_HLD_BIT = 2;  // invalidate_on_hold_enable
   localparam int CFG0_A20_BIT = 3;  // a20_mask_enable
   // config_reg_1 fields
   localparam int CFG1_RPL_BIT = 0;  // replacement_outputs_enable
   localparam int CFG1_WAY_BIT = 1;  // two-way set associative
   // control register fields
   localparam int CTRL_IF_BIT = 0;   // interrupt_flag_bit
   localparam int CTRL_PG_BIT = 1;   // paging enabled

   localparam logic [7:0] CFG0_RST = 8'h00;
   localparam logic [7:0] CFG1_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ----------------------------------------------------------------
   // Bus constants
   // ----------------------------------------------------------------
   localparam logic [23:1] COP_CTRL_PORT = 23'h40007c; // 80 00f8h
   localparam logic [23:1] COP_OPA_PORT = 23'h40007e;  // 80 00fch
   localparam logic [23:1] COP_OPB_PORT = 23'h40007f;  // 80 00feh
   localparam logic [23:1] ADDR_RST = 23'h7fffff;
   localparam logic [7:0] NMI_VECTOR = 8'h02;
   localparam logic [7:0] COP_EXC_VECTOR = 8'h10;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int DOUBLE_RATE_CLOCK_NS = CLK_NS / 2;
   localparam int NMI_LOW_DOUBLE_RATE_CLOCK = 8;
   localparam int NMI_LOW_NS = NMI_LOW_DOUBLE_RATE_CLOCK * DOUBLE_RATE_CLOCK_NS;
   localparam int NMI_LOW_CYC = (NMI_LOW_NS + CLK_NS - 1) / CLK_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_CORE, SRC_INTA1, SRC_INTA2, SRC_FILL2
   } src_t;

   typedef enum logic [1:0] {
      COP_PLAIN, COP_WAITING, COP_INIT_CLEAR, COP_NOWAIT_STORE
   } cop_kind_t;

endpackage
